/* rtl/wwdt_map.vh */
`ifndef WWDT_MAP_VH
`define WWDT_MAP_VH
// counter geometry
`define WWDT_CNT_W 24
`define WWDT_CNT_MAX 24'hFFFFFF
`define WWDT_CNT_MIN 24'h0000FF
// prescaler divides the tick clock by four
`define WWDT_PRE_W 2
`define WWDT_PRE_LAST 2'h3
// feed key bytes, first then second
`define WWDT_KEY1 8'hAA
`define WWDT_KEY2 8'h55
// reset values, and the warning compare width
`define WWDT_TC_RST 24'h0000FF
`define WWDT_WIN_RST 24'hFFFFFF
`define WWDT_WARN_RST 10'h000
`define WWDT_WARN_W 10
// reset pulse length in clk cycles
`define WWDT_RST_LEN 4'h8
`endif

/* rtl/wwdt_sync.v */
`timescale 1ns/1ps
// =========================================
// two-stage synchroniser for one level
module wwdt_sync (
    input wire clk, // system clock
    input wire reset, // async reset
    input wire ce, // clock enable
    input wire d, // asynchronous level
    output reg q_r // synchronised level
);
    reg meta_r; // first stage, read only by q_r
    // two flops in series
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_r <= 1'b0;
            q_r <= 1'b0;
        end else if (ce) begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end
endmodule

/* rtl/wwdt_core.v */
`timescale 1ns/1ps
`include "wwdt_map.vh"
module wwdt_core (
    input wire clk, // system clock
    input wire reset, // async reset, active high
    input wire ce, // clock enable, freezes all state
    input wire internal_rc_oscillator, // rc oscillator tick source
    input wire dedicated_watchdog_oscillator, // watchdog oscillator tick source
    input wire clk_sel, // 0 rc oscillator, 1 watchdog oscillator
    input wire enable_set, // pulse: set the enable
    input wire reset_mode_set, // pulse: select reset on event
    input wire [23:0] timeout_val, // programmed reload value
    input wire [23:0] window_val, // feeds allowed when counter at or below this
    input wire [9:0] warn_val, // warning compare value
    input wire feed_valid, // pulse: a feed byte is written
    input wire [7:0] feed_byte, // feed byte value
    input wire flag_clear, // pulse: clear reset and timeout flags
    input wire warn_clear, // pulse: clear warning flag
    output reg enabled_r, // watchdog running
    output reg reset_mode_r, // reset on event selected
    output reg [23:0] count_r, // current counter value
    output reg timeout_flag_r, // watchdog event happened
    output reg wdreset_flag_r, // last reset was from watchdog
    output reg warn_flag_r, // warning interrupt flag
    output reg wd_irq_r, // watchdog interrupt request
    output reg chip_reset_r // chip-wide reset request
);
    // =========================================
    // tick clock selection and synchronisers
    wire [1:0] osc_raw; // raw tick sources, 0 rc, 1 watchdog oscillator
    wire [1:0] osc_s; // synchronised tick sources
    reg tick_d_r; // previous tick level
    assign osc_raw = {dedicated_watchdog_oscillator, internal_rc_oscillator};
    // one synchroniser per tick source; both run, so a switch needs no settling
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            // each source crosses into clk through two flops
            wwdt_sync u_sync (
                .clk(clk), // system clock
                .reset(reset), // async reset
                .ce(ce), // freeze with the block
                .d(osc_raw[gi]), // raw source level
                .q_r(osc_s[gi]) // synchronised level
            );
        end
    endgenerate
    // pick the tick clock; a switch may give one stray edge
    wire tick_lvl = clk_sel ? osc_s[1] : osc_s[0];
    wire tick = tick_lvl & ~tick_d_r; // rising edge of tick clock
    // =========================================
    // feed sequence decode
    reg key1_seen_r; // first key byte accepted
    reg [1:0] pre_r; // prescaler
    reg [3:0] rst_cnt_r; // reset pulse length counter
    // one counter step per four tick edges
    wire pre_done = tick & (pre_r == `WWDT_PRE_LAST);
    // second key byte right after the first: a complete feed
    wire feed_ok = feed_valid & key1_seen_r & (feed_byte == `WWDT_KEY2);
    // any byte that breaks the two-byte key order
    wire feed_bad_seq = feed_valid & (key1_seen_r ? (feed_byte != `WWDT_KEY2)
        : (feed_byte != `WWDT_KEY1));
    // counter still above the window: too soon for a feed
    wire early = count_r > window_val;
    // a bad feed only counts while the watchdog runs
    wire bad_feed = enabled_r & (feed_bad_seq | (feed_ok & early));
    // a complete feed inside the window
    wire good_feed = feed_ok & ~early;
    // zero reached and one more step: time-out
    wire expire = enabled_r & pre_done & (count_r == 24'h000000);
    // either kind of watchdog event
    wire event_hit = expire | bad_feed; // watchdog event
    // clamp reload to the smallest legal period
    wire [23:0] reload = (timeout_val < `WWDT_CNT_MIN) ? `WWDT_CNT_MIN : timeout_val;
    // =========================================
    // main state
    // reload request: a good feed, or the enable being set from idle
    wire load_cnt = good_feed | (enable_set & ~enabled_r);
    // counter step: one per prescaler wrap while running
    wire step = enabled_r & pre_done;
    // warning point reached on this step
    wire warn_hit = step & (count_r == {14'h0000, warn_val});
    // an event that ends in a chip reset rather than an interrupt
    wire rst_event = event_hit & reset_mode_r;
    // =========================================
    // tick edge detector; its reset value is the idle level of the tick
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_d_r <= 1'b0; // idle low, so no false edge after reset
        end else if (ce) begin
            tick_d_r <= tick_lvl; // remember last level
        end
    end
    // =========================================
    // feed key tracker: set after the first key byte, cleared by the next feed byte of any value
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            key1_seen_r <= 1'b0; // no key seen
        end else if (ce) begin
            if (feed_valid) begin
                key1_seen_r <= ~key1_seen_r & (feed_byte == `WWDT_KEY1);
            end
        end
    end
    // =========================================
    // prescaler: four tick edges make one counter step
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_r <= 2'h0; // start of a step
        end else if (ce) begin
            if (load_cnt) begin
                pre_r <= 2'h0; // restart timing from the reload
            end else if (tick) begin
                pre_r <= pre_r + 2'h1;
            end
        end
    end
    // =========================================
    // enable: software can only set it, an event clears it
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            enabled_r <= 1'b0; // stopped after reset
        end else if (ce) begin
            if (event_hit) begin
                enabled_r <= 1'b0;
            end else if (enable_set) begin
                enabled_r <= 1'b1;
            end
        end
    end
    // =========================================
    // reset mode: set-only; unlike the enable, no event clears it
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            reset_mode_r <= 1'b0; // interrupt mode after reset
        end else if (ce) begin
            if (reset_mode_set) begin
                reset_mode_r <= 1'b1;
            end
        end
    end
    // =========================================
    // down-counter; it parks at zero until the expiry step
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            count_r <= `WWDT_TC_RST; // smallest period
        end else if (ce) begin
            if (load_cnt) begin
                count_r <= reload;
            end else if (step && count_r != 24'h000000) begin
                count_r <= count_r - 24'h000001;
            end
        end
    end
    // =========================================
    // warning flag, set wins over clear
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            warn_flag_r <= 1'b0; // no warning
        end else if (ce) begin
            if (warn_hit) begin
                warn_flag_r <= 1'b1;
            end else if (warn_clear) begin
                warn_flag_r <= 1'b0; // software clear
            end
        end
    end
    // =========================================
    // event flag, set wins over clear
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            timeout_flag_r <= 1'b0; // no event
        end else if (ce) begin
            if (event_hit) begin
                timeout_flag_r <= 1'b1;
            end else if (flag_clear) begin
                timeout_flag_r <= 1'b0; // software clear
            end
        end
    end
    // =========================================
    // interrupt request: one cycle per event in interrupt mode, or while warning stands
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_irq_r <= 1'b0; // quiet
        end else if (ce) begin
            wd_irq_r <= (event_hit & ~reset_mode_r) | warn_flag_r;
        end
    end
    // =========================================
    // chip reset pulse of fixed length
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rst_cnt_r <= 4'h0; // no pulse pending
            chip_reset_r <= 1'b0; // released
        end else if (ce) begin
            if (rst_event) begin
                rst_cnt_r <= `WWDT_RST_LEN;
                chip_reset_r <= 1'b1; // start pulse
            end else if (rst_cnt_r != 4'h0) begin
                rst_cnt_r <= rst_cnt_r - 4'h1; // count down
                chip_reset_r <= (rst_cnt_r != 4'h1); // drop on the last count
            end else begin
                chip_reset_r <= 1'b0; // idle
            end
        end
    end
    // =========================================
    // watchdog reset flag, set wins over clear; the async reset clears it like the other flags
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wdreset_flag_r <= 1'b0;
        end else if (ce) begin
            if (event_hit && reset_mode_r) begin
                wdreset_flag_r <= 1'b1;
            end else if (flag_clear) begin
                wdreset_flag_r <= 1'b0;
            end
        end
    end
endmodule

/* sim/wwdt_core_checker.sv */
`timescale 1ns/1ps
`include "wwdt_map.vh"
// =========================================
// port checker for the watchdog core
module wwdt_chk (
    input wire clk, input wire reset, // clock, reset
    input wire feed_valid, input wire [7:0] feed_byte, // feed
    input wire [23:0] timeout_val, input wire [23:0] count_r, // reload, counter
    input wire enabled_r, input wire reset_mode_r, input wire timeout_flag_r, // state
    input wire warn_flag_r, input wire wd_irq_r, input wire chip_reset_r // requests
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    en_drop_a: assert property ($fell(enabled_r) |-> timeout_flag_r) else $error("drop");
    expiry_a: assert property (enabled_r && count_r == 24'h0 |-> ##[1:20] timeout_flag_r)
        else $error("late");
    feed_load_a: assert property (feed_valid && feed_byte == `WWDT_KEY2
        && $past(feed_valid && feed_byte == `WWDT_KEY1) && timeout_val > 24'hFE
        && enabled_r && !timeout_flag_r |=> count_r == $past(timeout_val) || timeout_flag_r)
        else $error("reload");
    bad_feed_a: assert property (enabled_r && feed_valid && feed_byte != `WWDT_KEY2
        && $past(feed_valid && feed_byte == `WWDT_KEY1) |=> timeout_flag_r) else $error("bad");
    rst_len_a: assert property ($rose(chip_reset_r) |-> chip_reset_r [*8] ##1 !chip_reset_r)
        else $error("length");
    rst_mode_a: assert property (chip_reset_r |-> reset_mode_r) else $error("mode");
    ev_irq_a: assert property ($rose(timeout_flag_r) && !reset_mode_r |-> ##[0:1] wd_irq_r)
        else $error("irq");
    warn_irq_a: assert property (warn_flag_r |=> wd_irq_r) else $error("warn");
    cover property ($rose(chip_reset_r));
    cover property ($rose(warn_flag_r));
    cover property ($rose(wd_irq_r) && timeout_flag_r);
endmodule
bind wwdt_core wwdt_chk i_chk (.*);

/* sim/test_windowed_watchdog_timer.sv */
`timescale 1ns/1ps
// =========================================
// self-checking bench for the watchdog core
module test_windowed_watchdog_timer;
    reg clk = 1'b0, reset = 1'b1, sel = 1'b0, tick = 1'b0; // clock, reset, source, ticks
    reg [12:0] ctl = 13'h0; // strobes and feed byte
    reg ce = 1'b1; // clock enable
    reg [23:0] hold = 24'h0; // counter before a freeze
    reg [23:0] tv = 24'h100, wv = 24'hFFFFFF, wl = 24'h0; // reload, window, warning
    wire en, md, tf, wf, wn, irq, cr; // status
    wire [23:0] cnt; // counter
    integer n_fail = 0, checked = 0; // counts
    initial forever #25 clk = ~clk;
    initial forever #100 tick = ~tick; // source clock at a quarter of clk
    wwdt_core i_dut (.clk(clk), .reset(reset), .ce(ce), .internal_rc_oscillator(tick & ~sel),
        .dedicated_watchdog_oscillator(tick & sel), .clk_sel(sel), .enable_set(ctl[12]),
        .reset_mode_set(ctl[11]), .flag_clear(ctl[10]), .warn_clear(ctl[9]), .feed_valid(ctl[8]),
        .feed_byte(ctl[7:0]), .timeout_val(tv), .window_val(wv), .warn_val(wl[9:0]),
        .enabled_r(en), .reset_mode_r(md), .count_r(cnt), .timeout_flag_r(tf),
        .wdreset_flag_r(wf), .warn_flag_r(wn), .wd_irq_r(irq), .chip_reset_r(cr));
    task chk(input [31:0] seen, input [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t ns saw %h expected %h", $time, seen, exp);
        end
    endtask
    // two strobed cycles with bytes b1 then b2, then n idle cycles
    task op(input [4:0] v, input [7:0] b1, input [7:0] b2, input integer n);
        @(posedge clk) #1 ctl = {v, b1};
        @(posedge clk) #1 ctl[7:0] = b2;
        @(posedge clk) #1 ctl = 13'h0;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #501 reset = 1'b0;
        chk({cnt, en, md, tf, wf, wn, irq, cr}, 32'h7F80);
        op(5'h10, 8'h00, 8'h00, 200);
        chk({en, cnt < 24'h100}, 32'h3);
        op(5'h01, 8'hAA, 8'h55, 0);
        chk(cnt, tv);
        op(5'h01, 8'hAA, 8'h12, 2);
        chk({tf, en}, 32'h2);
        wv = 24'h10;
        op(5'h14, 8'h00, 8'h00, 0);
        op(5'h01, 8'hAA, 8'h55, 2);
        chk({tf, en}, 32'h2);
        {wv, wl, tv, sel} = {24'hFFFFFF, 24'hF8, 24'hFF, 1'b1};
        op(5'h14, 8'h00, 8'h00, 200);
        chk({wn, irq}, 32'h3);
        op(5'h0A, 8'h00, 8'h00, 0);
        chk(wn, 32'h0);
        ce = 1'b0;
        hold = cnt;
        repeat (100) @(posedge clk);
        #1 chk(cnt, hold);
        ce = 1'b1;
        op(5'h00, 8'h00, 8'h00, 3000);
        chk(tf, 32'h0);
        op(5'h00, 8'h00, 8'h00, 1200);
        chk({tf, wf, en, cr}, 32'hC);
        summarize;
    end
endmodule
